/* core/pwp_top.sv */
// Overview of operation
// - Writing one releases high-impedance; bit self-clears.
// - B-side select zero: disabled B pins use own polarity.
// - Phase A comp: zero copies, one inverts main.
// - Phase C comp: zero copies, one inverts main.
// - Overflow sets sticky flag; write one clears.
// - Bottom in back-to-back sets flag; write-one clears.
// - Channel A match sets flag; write-one clears.
// - B match sets flag; write one clears.
// - C match sets flag; write one clears.
// - Overflow mask bit enables overflow interrupt.
// - Bottom mask bit enables bottom interrupt.
// - Channel A mask enables A match interrupt.
// - Channel B mask enables B match interrupt.
// - Channel C mask enables C interrupt; reset zero.
`default_nettype none
`include "pwp_map.svh"
module pwp_top #(
  parameter int ADR_W = 16
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire pwp_pkg::pwp_wave_type wave_i,
  input wire pwp_pkg::pwp_pin_type pin_en_i,
  input wire logic hiz_req_i,
  input wire logic btb_mode_i,
  input wire pwp_pkg::pwp_evt_type evt_i,
  output pwp_pkg::pwp_pin_type pin_lvl_o,
  output pwp_pkg::pwp_pin_type pin_oe_o,
  output logic irq_o
);
  import pwp_pkg::*;

  // Refuse address buses too narrow for the register indices
  if (ADR_W < 16) begin : g_chk
    $error("pwp_top: ADR_W must be at least 16");
  end

  localparam pwp_state_type RST_STATE = '{
    pol: `PWP_POL_RST,
    hiz: 1'b0,
    stat: `PWP_STAT_RST,
    mask: `PWP_MASK_RST,
    ack: 1'b0,
    rdat: 8'h00,
    lvl: '0,
    oe: '0,
    irq: 1'b0
  };

  // Register index match on a byte address
  function automatic logic hit(input logic [15:0] adr, input logic [13:0] idx);
    hit = (adr[15:2] == idx);
  endfunction

  // Main pin level from enable, raw wave and polarity
  function automatic logic main_lvl(input logic en, input logic w, input logic pol);
    main_lvl = en ? (w ^ pol) : pol;
  endfunction

  // Complementary pin level from main level, inversion and disabled choice
  function automatic logic comp_lvl(input logic en, input logic m, input logic inv,
                                    input logic sel);
    if (en) begin
      comp_lvl = m ^ inv;
    end else begin
      comp_lvl = sel ? `PWP_BDIS_LVL : inv;
    end
  endfunction

  pwp_state_type s_q;
  pwp_state_type s_d;
  logic req;
  logic wr;
  logic [15:0] adr;
  logic [4:0] ev;
  logic [4:0] clr;
  logic rel;
  logic sel;

  assign adr = wb_adr_i[15:0];
  assign req = wb_cyc_i & wb_stb_i;
  assign wr = req & s_q.ack & wb_we_i & wb_sel_i[0];
  assign sel = s_q.pol[`PWP_POL_SEL_BIT];

  // Event vector in status layout; bottom only counts in back-to-back mode
  assign ev = {evt_i.overflow, evt_i.bottom & btb_mode_i, evt_i.chan_a_match,
               evt_i.chan_b_match, evt_i.chan_c_match};

  // Write-one-to-clear strobes and high-impedance release
  assign clr = (wr && hit(adr, `PWP_IDX_STAT)) ? wb_dat_i[`PWP_IRQ_HI:`PWP_IRQ_LO] : 5'h00;
  assign rel = wr && hit(adr, `PWP_IDX_POL) && wb_dat_i[`PWP_POL_HIZ_BIT];

  // Next state
  always_comb begin
    s_d = s_q;
    // Bus answer: one-cycle ack, write committed in the ack cycle
    s_d.ack = req & ~s_q.ack;
    if (req & ~s_q.ack) begin
      if (hit(adr, `PWP_IDX_POL)) begin
        s_d.rdat = {1'b0, s_q.pol};
      end else if (hit(adr, `PWP_IDX_STAT)) begin
        s_d.rdat = {s_q.stat, `PWP_LOW_ZERO};
      end else if (hit(adr, `PWP_IDX_MASK)) begin
        s_d.rdat = {s_q.mask, `PWP_LOW_ZERO};
      end else begin
        s_d.rdat = 8'h00;
      end
    end
    if (wr && hit(adr, `PWP_IDX_POL)) begin
      s_d.pol = wb_dat_i[`PWP_POL_SEL_BIT:`PWP_POL_CB_BIT];
    end
    if (wr && hit(adr, `PWP_IDX_MASK)) begin
      s_d.mask = wb_dat_i[`PWP_IRQ_HI:`PWP_IRQ_LO];
    end
    // Sticky flags; a new event wins over a clear in the same cycle
    s_d.stat = (s_q.stat & ~clr) | ev;
    // High-impedance request wins over a release
    s_d.hiz = hiz_req_i | (s_q.hiz & ~rel);
    // Pin levels
    s_d.lvl.phase_a_main_pin = main_lvl(pin_en_i.phase_a_main_pin, wave_i.phase_a,
                                        s_q.pol[`PWP_POL_AA_BIT]);
    s_d.lvl.phase_b_main_pin = main_lvl(pin_en_i.phase_b_main_pin, wave_i.phase_b,
                                        s_q.pol[`PWP_POL_BA_BIT]);
    s_d.lvl.phase_c_main_pin = main_lvl(pin_en_i.phase_c_main_pin, wave_i.phase_c,
                                        s_q.pol[`PWP_POL_CA_BIT]);
    s_d.lvl.phase_a_comp_pin = comp_lvl(pin_en_i.phase_a_comp_pin,
                                        s_d.lvl.phase_a_main_pin,
                                        s_q.pol[`PWP_POL_AB_BIT], sel);
    s_d.lvl.phase_b_comp_pin = comp_lvl(pin_en_i.phase_b_comp_pin,
                                        s_d.lvl.phase_b_main_pin,
                                        s_q.pol[`PWP_POL_BB_BIT], sel);
    s_d.lvl.phase_c_comp_pin = comp_lvl(pin_en_i.phase_c_comp_pin,
                                        s_d.lvl.phase_c_main_pin,
                                        s_q.pol[`PWP_POL_CB_BIT], sel);
    // All six pins float while high impedance is held
    s_d.oe = s_d.hiz ? '0 : '1;
    // Interrupt from the next flags and mask
    s_d.irq = |(s_d.stat & s_d.mask);
  end

  // State register, synchronous reset
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      s_q <= RST_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign wb_dat_o = {`PWP_UPPER_ZERO, s_q.rdat};
  assign wb_ack_o = s_q.ack;
  assign pin_lvl_o = s_q.lvl;
  assign pin_oe_o = s_q.oe;
  assign irq_o = s_q.irq;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  // Release write, no new request: all pins driven next cycle
  property p_hiz_rel;
    rel && !hiz_req_i |=> (pin_oe_o == '1);
  endproperty
  a_hiz_rel: assert property (p_hiz_rel) else $error("pins not driven after release");

  // Release bit always reads back zero
  property p_hiz_rd;
    wb_ack_o && !wb_we_i && hit(adr, `PWP_IDX_POL) |-> !wb_dat_o[`PWP_POL_HIZ_BIT];
  endproperty
  a_hiz_rd: assert property (p_hiz_rd) else $error("release bit read as one");

  // Request floats pins until a release
  property p_hiz_hold;
    hiz_req_i ##1 !rel |=> (pin_oe_o == '0);
  endproperty
  a_hiz_hold: assert property (p_hiz_hold) else $error("pins driven during hiz");

  // Disabled B pin, own polarity selected
  property p_bdis;
    !sel && !pin_en_i.phase_a_comp_pin && $stable(s_q.pol)
      |=> pin_lvl_o.phase_a_comp_pin == $past(s_q.pol[`PWP_POL_AB_BIT]);
  endproperty
  a_bdis: assert property (p_bdis) else $error("disabled B level wrong");

  // Disabled B pin, independent level selected
  property p_bdis_ind;
    sel && !pin_en_i.phase_c_comp_pin |=> pin_lvl_o.phase_c_comp_pin == `PWP_BDIS_LVL;
  endproperty
  a_bdis_ind: assert property (p_bdis_ind) else $error("independent B level wrong");

  // Disabled main pins idle at their polarity
  property p_main_idle;
    !pin_en_i.phase_a_main_pin && !pin_en_i.phase_b_main_pin &&
      !pin_en_i.phase_c_main_pin && $stable(s_q.pol)
      |=> pin_lvl_o.phase_a_main_pin == $past(s_q.pol[`PWP_POL_AA_BIT]) &&
          pin_lvl_o.phase_b_main_pin == $past(s_q.pol[`PWP_POL_BA_BIT]) &&
          pin_lvl_o.phase_c_main_pin == $past(s_q.pol[`PWP_POL_CA_BIT]);
  endproperty
  a_main_idle: assert property (p_main_idle) else $error("main idle level wrong");

  // Enabled main pin, polarity zero follows the raw wave
  property p_main_run;
    pin_en_i.phase_b_main_pin && !s_q.pol[`PWP_POL_BA_BIT] && $stable(s_q.pol)
      |=> pin_lvl_o.phase_b_main_pin == $past(wave_i.phase_b);
  endproperty
  a_main_run: assert property (p_main_run) else $error("main wave wrong");

  // Enabled main pin, polarity one inverts the raw wave
  property p_main_inv;
    pin_en_i.phase_c_main_pin && s_q.pol[`PWP_POL_CA_BIT] && $stable(s_q.pol)
      |=> pin_lvl_o.phase_c_main_pin == !$past(wave_i.phase_c);
  endproperty
  a_main_inv: assert property (p_main_inv) else $error("main inverse wrong");

  // Enabled comp pins track their main pin
  property p_comp;
    pin_en_i.phase_a_comp_pin && pin_en_i.phase_b_comp_pin &&
      pin_en_i.phase_c_comp_pin && $stable(s_q.pol)
      |=> (pin_lvl_o.phase_a_comp_pin ==
           (pin_lvl_o.phase_a_main_pin ^ $past(s_q.pol[`PWP_POL_AB_BIT]))) &&
          (pin_lvl_o.phase_b_comp_pin ==
           (pin_lvl_o.phase_b_main_pin ^ $past(s_q.pol[`PWP_POL_BB_BIT]))) &&
          (pin_lvl_o.phase_c_comp_pin ==
           (pin_lvl_o.phase_c_main_pin ^ $past(s_q.pol[`PWP_POL_CB_BIT])));
  endproperty
  a_comp: assert property (p_comp) else $error("comp pin mismatch");

  // Event sets its flag next cycle, even against a clear
  property p_set;
    ev != 5'h00 |=> (s_q.stat & $past(ev)) == $past(ev);
  endproperty
  a_set: assert property (p_set) else $error("flag not set");

  // Bottom outside back-to-back mode does not set a clear flag
  property p_btm_gate;
    evt_i.bottom && !btb_mode_i && !s_q.stat[`PWP_IRQ_BTM] |=> !s_q.stat[`PWP_IRQ_BTM];
  endproperty
  a_btm_gate: assert property (p_btm_gate) else $error("bottom set outside mode");

  // Write one clears a flag when no event arrives
  sequence s_clr;
    (clr & ~ev) != 5'h00;
  endsequence
  property p_clr;
    s_clr |=> (s_q.stat & $past(clr & ~ev)) == 5'h00;
  endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared");

  // Interrupt line equals the gated flags
  property p_irq;
    irq_o == |(s_q.stat & s_q.mask);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  // Masked event raises the line within one cycle only if enabled
  property p_irq_mask;
    evt_i.chan_c_match && !s_q.mask[`PWP_IRQ_CMC] &&
      s_q.stat[`PWP_IRQ_OVF:`PWP_IRQ_CMB] == 4'h0 && ev[`PWP_IRQ_OVF:`PWP_IRQ_CMB] == 4'h0 &&
      !(wr && hit(adr, `PWP_IDX_MASK)) |=> !irq_o;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq seen");

  // Bus: one-cycle ack after a request
  sequence s_req;
    req && !wb_ack_o;
  endsequence
  property p_ack;
    s_req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack timing wrong");

  // No request, no answer
  property p_ack_idle;
    !req |=> !wb_ack_o;
  endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("ack without request");

  // Upper read lanes stay zero while ack stands
  property p_upper_zero;
    wb_ack_o |-> wb_dat_o[31:8] == `PWP_UPPER_ZERO;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper lanes not zero");

  // Unused low bits of status and mask read zero
  property p_low_zero;
    wb_ack_o && !wb_we_i && (hit(adr, `PWP_IDX_STAT) || hit(adr, `PWP_IDX_MASK))
      |-> wb_dat_o[`PWP_IRQ_LO-1:0] == `PWP_LOW_ZERO;
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("low flag bits not zero");

  // Unmapped reads return zero
  property p_unmapped;
    req && !wb_ack_o && !hit(adr, `PWP_IDX_POL) && !hit(adr, `PWP_IDX_STAT) &&
      !hit(adr, `PWP_IDX_MASK) |=> wb_dat_o == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  // Polarity write stores the seven control bits
  property p_pol_wr;
    wr && hit(adr, `PWP_IDX_POL)
      |=> s_q.pol == $past(wb_dat_i[`PWP_POL_SEL_BIT:`PWP_POL_CB_BIT]);
  endproperty
  a_pol_wr: assert property (p_pol_wr) else $error("polarity write lost");

  // Polarity readback shows the stored bits
  property p_pol_rd;
    req && !wb_ack_o && !wb_we_i && hit(adr, `PWP_IDX_POL)
      |=> wb_dat_o[`PWP_POL_SEL_BIT:`PWP_POL_CB_BIT] == $past(s_q.pol);
  endproperty
  a_pol_rd: assert property (p_pol_rd) else $error("polarity readback wrong");

  // Mask write stores the five enables
  property p_mask_wr;
    wr && hit(adr, `PWP_IDX_MASK)
      |=> s_q.mask == $past(wb_dat_i[`PWP_IRQ_HI:`PWP_IRQ_LO]);
  endproperty
  a_mask_wr: assert property (p_mask_wr) else $error("mask write lost");

  // Writes without the low byte lane leave the registers alone
  property p_sel_gate;
    req && wb_ack_o && wb_we_i && !wb_sel_i[0] |=> $stable(s_q.pol) && $stable(s_q.mask);
  endproperty
  a_sel_gate: assert property (p_sel_gate) else $error("write without lane stored");

  // Flags hold with no event and no clear
  property p_stat_hold;
    ev == 5'h00 && clr == 5'h00 |=> $stable(s_q.stat);
  endproperty
  a_stat_hold: assert property (p_stat_hold) else $error("flag moved");

  // Bottom in back-to-back mode sets its flag
  property p_btm_set;
    evt_i.bottom && btb_mode_i |=> s_q.stat[`PWP_IRQ_BTM];
  endproperty
  a_btm_set: assert property (p_btm_set) else $error("bottom flag not set");

  // Request floats all pins next cycle, whatever the bus does
  property p_hiz_req;
    hiz_req_i |=> pin_oe_o == '0;
  endproperty
  a_hiz_req: assert property (p_hiz_req) else $error("pins driven after request");

  // Unmasked overflow raises the line next cycle
  property p_ovf_irq;
    ev[`PWP_IRQ_OVF] && s_q.mask[`PWP_IRQ_OVF] && !(wr && hit(adr, `PWP_IDX_MASK))
      |=> irq_o;
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("overflow irq missing");

  // Unmasked bottom raises the line next cycle
  property p_btm_irq;
    ev[`PWP_IRQ_BTM] && s_q.mask[`PWP_IRQ_BTM] && !(wr && hit(adr, `PWP_IDX_MASK))
      |=> irq_o;
  endproperty
  a_btm_irq: assert property (p_btm_irq) else $error("bottom irq missing");

  // Unmasked channel A match raises the line next cycle
  property p_cma_irq;
    ev[`PWP_IRQ_CMA] && s_q.mask[`PWP_IRQ_CMA] && !(wr && hit(adr, `PWP_IDX_MASK))
      |=> irq_o;
  endproperty
  a_cma_irq: assert property (p_cma_irq) else $error("chan a irq missing");

  // Unmasked channel B match raises the line next cycle
  property p_cmb_irq;
    ev[`PWP_IRQ_CMB] && s_q.mask[`PWP_IRQ_CMB] && !(wr && hit(adr, `PWP_IDX_MASK))
      |=> irq_o;
  endproperty
  a_cmb_irq: assert property (p_cmb_irq) else $error("chan b irq missing");

  // Unmasked channel C match raises the line next cycle
  property p_cmc_irq;
    ev[`PWP_IRQ_CMC] && s_q.mask[`PWP_IRQ_CMC] && !(wr && hit(adr, `PWP_IDX_MASK))
      |=> irq_o;
  endproperty
  a_cmc_irq: assert property (p_cmc_irq) else $error("chan c irq missing");
endmodule
`default_nettype wire

/* core/pwp_map.svh */
`ifndef PWP_MAP_SVH
`define PWP_MAP_SVH
// Register indices; the byte address is four times the index
`define PWP_IDX_POL 14'h1005
`define PWP_IDX_STAT 14'h1006
`define PWP_IDX_MASK 14'h1007
// Polarity control register field positions
`define PWP_POL_HIZ_BIT 7
`define PWP_POL_SEL_BIT 6
`define PWP_POL_AA_BIT 5
`define PWP_POL_AB_BIT 4
`define PWP_POL_BA_BIT 3
`define PWP_POL_BB_BIT 2
`define PWP_POL_CA_BIT 1
`define PWP_POL_CB_BIT 0
// Status and mask field positions (same layout)
`define PWP_IRQ_HI 7
`define PWP_IRQ_LO 3
`define PWP_IRQ_OVF 4
`define PWP_IRQ_BTM 3
`define PWP_IRQ_CMA 2
`define PWP_IRQ_CMB 1
`define PWP_IRQ_CMC 0
// Reset values
`define PWP_POL_RST 7'h00
`define PWP_STAT_RST 5'h00
`define PWP_MASK_RST 5'h00
// Level of a disabled B pin when the independent choice is selected
`define PWP_BDIS_LVL 1'b0
// Read padding
`define PWP_LOW_ZERO 3'h0
`define PWP_UPPER_ZERO 24'h00_0000
`endif

/* core/pwp_pkg.sv */
`default_nettype none
package pwp_pkg;
  // One bit per output pin
  typedef struct packed {
    logic phase_a_main_pin;
    logic phase_a_comp_pin;
    logic phase_b_main_pin;
    logic phase_b_comp_pin;
    logic phase_c_main_pin;
    logic phase_c_comp_pin;
  } pwp_pin_type;

  // Timer events, one-cycle pulses
  typedef struct packed {
    logic overflow;
    logic bottom;
    logic chan_a_match;
    logic chan_b_match;
    logic chan_c_match;
  } pwp_evt_type;

  // Raw duty waveform per phase, high during the duty part of a period
  typedef struct packed {
    logic phase_a;
    logic phase_b;
    logic phase_c;
  } pwp_wave_type;

  // Whole block state
  typedef struct packed {
    logic [6:0] pol;
    logic hiz;
    logic [4:0] stat;
    logic [4:0] mask;
    logic ack;
    logic [7:0] rdat;
    pwp_pin_type lvl;
    pwp_pin_type oe;
    logic irq;
  } pwp_state_type;
endpackage
`default_nettype wire

/* tb/pwp_switch_model.sv */
`default_nettype none
// Gate drivers of the external switches; a floating pin is pulled down
module pwp_switch_model
  import pwp_pkg::*;
(
  input wire pwp_pkg::pwp_pin_type lvl_i,
  input wire pwp_pkg::pwp_pin_type oe_i,
  output pwp_pkg::pwp_pin_type gate_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Driven pins pass their level, released pins read low
  assign gate_o = lvl_i & oe_i;
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pwp_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [3:0] wsel = 4'hf;
  logic [31:0] dat;
  logic [31:0] rdat;
  logic ack;
  pwp_wave_type wave = '0;
  pwp_pin_type en = '0;
  pwp_pin_type lvl;
  pwp_pin_type oe;
  pwp_pin_type gate;
  pwp_evt_type evt = '0;
  logic hiz = 1'b0;
  logic btb = 1'b0;
  logic irq;
  int failures = 0;
  int num_checks = 0;
  // Free running clock
  initial forever #5 clk = ~clk;
  pwp_top pwp_top_i (.ref_clk_i(clk), .nrst_i(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat),
    .wb_ack_o(ack), .wave_i(wave), .pin_en_i(en), .hiz_req_i(hiz), .btb_mode_i(btb),
    .evt_i(evt), .pin_lvl_o(lvl), .pin_oe_o(oe), .irq_o(irq));
  pwp_switch_model pwp_switch_model_i (.lvl_i(lvl), .oe_i(oe), .gate_o(gate));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Classic single Wishbone cycle, waits for ack
  task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= wsel;
    wdat <= {24'h00_0000, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rdat = dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Expected pin levels of all three phases
  function automatic logic [5:0] exp_pins(logic [6:0] p, logic [5:0] e, logic [2:0] w);
    logic m;
    logic [5:0] r;
    for (int k = 0; k < 3; k++) begin
      m = e[5-2*k] ? w[2-k] ^ p[5-2*k] : p[5-2*k];
      r[5-2*k] = m;
      r[4-2*k] = e[4-2*k] ? m ^ p[4-2*k] : (p[6] ? 1'b0 : p[4-2*k]);
    end
    return r;
  endfunction
  task automatic t_reset();
    wb(1'b0, 16'h4014, 8'h00);
    chk("pol rst", rdat, 32'h0000_0000);
    wb(1'b0, 16'h4018, 8'h00);
    chk("stat rst", rdat, 32'h0000_0000);
    wb(1'b0, 16'h401c, 8'h00);
    chk("mask rst", rdat, 32'h0000_0000);
    wb(1'b0, 16'h4020, 8'h00);
    chk("unmapped", rdat, 32'h0000_0000);
    wb(1'b1, 16'h4020, 8'hff);
    wb(1'b0, 16'h4014, 8'h00);
    chk("unmapped wr", rdat, 32'h0000_0000);
    wsel = 4'he;
    wb(1'b1, 16'h401c, 8'hf8);
    wsel = 4'hf;
    wb(1'b0, 16'h401c, 8'h00);
    chk("sel0 wr", rdat, 32'h0000_0000);
    $display("test reset done");
  endtask
  task automatic t_pol();
    logic [7:0] pv [6] = '{8'h00, 8'h15, 8'h2a, 8'h3f, 8'h7f, 8'h40};
    logic [5:0] ev [3] = '{6'h00, 6'h3f, 6'h2a};
    logic [5:0] x;
    for (int i = 0; i < 6; i++) begin
      wb(1'b1, 16'h4014, pv[i]);
      for (int j = 0; j < 6; j++) begin
        @(posedge clk);
        en <= ev[j%3];
        wave <= (j < 3) ? 3'b101 : 3'b010;
        tick(2);
        x = exp_pins(pv[i][6:0], ev[j%3], (j < 3) ? 3'b101 : 3'b010);
        chk("pins", lvl, x);
        chk("gate", gate, x);
        chk("oe run", oe, 32'h0000_003f);
      end
    end
    $display("test polarity done");
  endtask
  task automatic t_hiz();
    @(posedge clk);
    hiz <= 1'b1;
    @(posedge clk);
    hiz <= 1'b0;
    tick(1);
    chk("oe hiz", oe, 32'h0000_0000);
    chk("gate hiz", gate, 32'h0000_0000);
    wb(1'b1, 16'h4014, 8'h00);
    tick(2);
    chk("oe zero wr", oe, 32'h0000_0000);
    wb(1'b1, 16'h4014, 8'h80);
    tick(1);
    chk("oe release", oe, 32'h0000_003f);
    wb(1'b0, 16'h4014, 8'h00);
    chk("hiz bit", rdat, 32'h0000_0000);
    $display("test hiz done");
  endtask
  task automatic t_irq();
    logic [7:0] b;
    btb <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      b = 8'h80 >> i;
      wb(1'b1, 16'h401c, 8'h00);
      @(posedge clk);
      evt <= 5'b10000 >> i;
      @(posedge clk);
      evt <= '0;
      tick(1);
      chk("irq masked", irq, 32'h0000_0000);
      wb(1'b0, 16'h4018, 8'h00);
      chk("stat set", rdat, b);
      wb(1'b1, 16'h401c, b);
      tick(1);
      chk("irq on", irq, 32'h0000_0001);
      wb(1'b0, 16'h401c, 8'h00);
      chk("mask rd", rdat, b);
      wb(1'b1, 16'h4018, b);
      tick(1);
      chk("irq clr", irq, 32'h0000_0000);
      wb(1'b0, 16'h4018, 8'h00);
      chk("stat clr", rdat, 32'h0000_0000);
    end
    btb <= 1'b0;
    @(posedge clk);
    evt <= 5'b01000;
    @(posedge clk);
    evt <= '0;
    wb(1'b0, 16'h4018, 8'h00);
    chk("no btb", rdat, 32'h0000_0000);
    $display("test irq done");
  endtask
  // Event and write-one clear on the same edge: the event wins
  task automatic t_clash();
    @(posedge clk);
    evt <= 5'b10000;
    @(posedge clk);
    evt <= '0;
    fork
      wb(1'b1, 16'h4018, 8'h80);
      begin
        repeat (2) @(posedge clk);
        evt <= 5'b10000;
        @(posedge clk);
        evt <= '0;
      end
    join
    wb(1'b0, 16'h4018, 8'h00);
    chk("set wins", rdat, 32'h0000_0080);
    wb(1'b1, 16'h4018, 8'h80);
    wb(1'b0, 16'h4018, 8'h00);
    chk("clr after", rdat, 32'h0000_0000);
    $display("test clash done");
  endtask
  // Reset in mid-run with registers and flags loaded
  task automatic t_rerst();
    wb(1'b1, 16'h4014, 8'h7f);
    wb(1'b1, 16'h401c, 8'hf8);
    @(posedge clk);
    evt <= 5'b11111;
    @(posedge clk);
    evt <= '0;
    tick(1);
    chk("irq pre", irq, 32'h0000_0001);
    @(posedge clk);
    nrst <= 1'b0;
    tick(2);
    chk("oe rst", oe, 32'h0000_0000);
    chk("irq rst", irq, 32'h0000_0000);
    @(posedge clk);
    nrst <= 1'b1;
    tick(2);
    chk("oe after rst", oe, 32'h0000_003f);
    chk("pins after rst", lvl, exp_pins(7'h00, en, wave));
    wb(1'b0, 16'h4014, 8'h00);
    chk("pol rerst", rdat, 32'h0000_0000);
    wb(1'b0, 16'h4018, 8'h00);
    chk("stat rerst", rdat, 32'h0000_0000);
    wb(1'b0, 16'h401c, 8'h00);
    chk("mask rerst", rdat, 32'h0000_0000);
    $display("test rerst done");
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_pol();
    t_hiz();
    t_irq();
    t_clash();
    t_rerst();
    wrap_up();
  end
  // Watchdog
  initial begin
    #100us;
    failures++;
    wrap_up();
  end
endmodule
`default_nettype wire
